// ---- bench/dfip_src.sv ----
// source model of the framed ddr byte link
// assumes mclk is the bench clock; the byte clock stands still between groups
`timescale 1ns/1ps
module dfip_src (
  input wire logic mclk, // bench clock
  output logic fbc, // forwarded byte clock
  output logic [dfip_pkg::LANE_W-1:0] lanes, // byte lanes
  output logic frame // frame marker
);
  initial
  begin
    fbc = 1'b0;
    lanes = 8'h00;
    frame = 1'b0;
  end

  // one edge per byte, each level held four cycles; n below 4 leaves a partial group
  task automatic send(input logic [31:0] w, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk);
      fbc <= ~fbc;
      lanes <= w[31-8*i -: 8];
      frame <= (i == 0);
      repeat (3) @(posedge mclk);
    end
    @(posedge mclk);
    // released lanes show no stale byte
    lanes <= ~lanes;
    frame <= 1'b0;
  endtask
endmodule

// ---- bench/tb_top.sv ----
// bench top: streams groups through the port and checks codes and pin roles
// assumes the design's own assertions guard cycle timing of div_tick and sync
`timescale 1ns/1ps
module tb_top;
  import dfip_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cclk = 1'b0;
  logic strobe = 1'b0;
  logic gate = 1'b0;
  logic rev = 1'b0;
  logic ext_ref = 1'b0;
  logic four = 1'b0;
  logic sel_n = 1'b1;
  logic sclk = 1'b0;
  logic sdio = 1'b0;
  logic fbc;
  logic [LANE_W-1:0] lanes;
  logic frame;
  dfip_serial_type pins;
  logic ref_oe;
  dfip_analog_type codes;
  logic tick;
  logic [2:0] ccnt = 3'h0;
  logic [15:0] seed = 16'h0029;
  logic [31:0] w;
  logic [31:0] exp_q[$];
  int ticks = 0;
  int t0 = 0;
  int bad_count = 0;
  int samples_checked = 0;

  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    ccnt <= ccnt + 3'h1;
    if (ccnt[1:0] == 2'h3)
      cclk <= ~cclk;
    if (tick === 1'b1)
      ticks <= ticks + 1;
  end

  dfip_src i_src (.mclk(mclk), .fbc(fbc), .lanes(lanes), .frame(frame));
  dfip_top i_dut (.mclk(mclk), .srst(srst), .forwarded_byte_clock(fbc), .byte_lanes(lanes),
    .frame_marker(frame), .converter_clock(cclk), .divider_sync_strobe(strobe),
    .transmit_gate(gate), .lane_reverse(rev), .ext_ref_select(ext_ref),
    .four_wire_select(four), .serial_select_n(sel_n), .serial_clock(sclk), .sdio_in(sdio),
    .serial_pins(pins), .reference_pin_oe(ref_oe), .dac_codes(codes), .div_tick(tick));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // reference model: optional bit reversal per byte, true is inverse, comp is sample
  function automatic logic [63:0] model(input logic [31:0] v, input logic r);
    logic [31:0] u;
    u = v;
    if (r)
      for (int i = 0; i < 32; i++)
        u[i] = v[(i / 8) * 8 + 7 - (i % 8)];
    return {~u[31:16], u[31:16], ~u[15:0], u[15:0]};
  endfunction

  task automatic chk(input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic final_report;
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(model(32'h0, 1'b0), codes);
    gate <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int k = 0; k < 6; k++)
    begin
      rev <= k[0];
      seed = lfsr(seed);
      w[31:16] = seed;
      seed = lfsr(seed);
      w[15:0] = seed;
      if (k < 2)
        w = {32{k[0]}};
      exp_q.push_back(w);
      if (k == 2)
        i_src.send(~w, 2);
      i_src.send(w, 4);
      repeat (40) @(posedge mclk);
      chk(model(exp_q.pop_front(), k[0]), codes);
    end
    gate <= 1'b0;
    repeat (5) @(posedge mclk);
    chk(model(32'h0, 1'b0), codes);
    i_src.send(32'h1234_5678, 4);
    gate <= 1'b1;
    repeat (40) @(posedge mclk);
    chk(model(32'h0, 1'b0), codes);
    for (int r = 0; r < 2; r++)
    begin
      ext_ref <= r[0];
      repeat (3) @(posedge mclk);
      chk({63'h0, ~r[0]}, {63'h0, ref_oe});
    end
    for (int m = 0; m < 2; m++)
    begin
      four <= m[0];
      sel_n <= 1'b0;
      seed = lfsr(seed);
      for (int i = 7; i >= 0; i--)
      begin
        sdio <= seed[i];
        repeat (4) @(posedge mclk);
        sclk <= 1'b1;
        repeat (4) @(posedge mclk);
        sclk <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      if (m == 0)
        chk({61'h0, seed[7], 2'h3}, {61'h0, pins});
      else
        chk({62'h0, 1'b0, seed[7]}, {62'h0, pins.sdio_oe, pins.alarm_serial_out});
      sel_n <= 1'b1;
      sdio <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(64'h0, {63'h0, pins.sdio_oe});
    end
    t0 = ticks;
    repeat (40) @(posedge mclk);
    strobe <= 1'b1;
    repeat (20) @(posedge mclk);
    strobe <= 1'b0;
    repeat (100) @(posedge mclk);
    chk(64'h1, {63'h0, ticks - t0 >= 8 && ticks - t0 <= 11});
    final_report();
  end

  initial
  begin
    #50000;
    bad_count++;
    final_report();
  end
endmodule

// ---- hw/dfip_mem.sv ----
// small sample store of the input fifo, registered read data
// assumes the owner keeps its own pointers and never reads and writes one word in a cycle
`timescale 1ns/1ps
module dfip_mem #(
  parameter int WIDTH = 32,
  parameter int AW = 3
) (
  input wire logic mclk, // system clock
  input wire logic wr_en, // write strobe
  input wire logic [AW-1:0] wr_addr, // write address
  input wire logic [WIDTH-1:0] wr_data, // write word
  input wire logic [AW-1:0] rd_addr, // read address
  output logic [WIDTH-1:0] rd_data // read word, one cycle after address
);
  typedef struct packed {
    logic [(1<<AW)-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd;
  } dfip_mem_st_type;

  dfip_mem_st_type st_ff;
  dfip_mem_st_type nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (wr_en)
    begin
      nxt_st.mem[wr_addr] = wr_data;
    end
    nxt_st.rd = st_ff.mem[rd_addr];
  end

  // no reset: contents are flushed by the pointers, not cleared
  always_ff @(posedge mclk)
  begin
    st_ff <= nxt_st;
  end

  assign rd_data = st_ff.rd;
endmodule

// ---- hw/dfip_pkg.sv ----
// constants and carrier types for the framed double-data-rate input port
// assumes one 100 MHz clock; every pin is slow enough to be oversampled by it
package dfip_pkg;
  localparam int LANE_W = 8;
  localparam int SAMPLE_W = 16;
  localparam int FIFO_AW = 3;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_RATIO_DEFAULT = 4'h2;
  localparam logic [1:0] LAST_BYTE_IDX = 2'h3;
  localparam logic [1:0] FIRST_NEXT_IDX = 2'h1;
  localparam logic [SAMPLE_W-1:0] ZERO_CODE = 16'h0000;
  localparam logic [3:0] SER_CMD_BITS = 4'h8;
  localparam logic [3:0] SER_ALL_BITS = 4'hf;

  typedef struct packed {
    logic [SAMPLE_W-1:0] a;
    logic [SAMPLE_W-1:0] b;
  } dfip_pair_type;

  // sink magnitudes: all ones is full-scale sink, zero is no current
  typedef struct packed {
    logic [SAMPLE_W-1:0] a_true;
    logic [SAMPLE_W-1:0] a_comp;
    logic [SAMPLE_W-1:0] b_true;
    logic [SAMPLE_W-1:0] b_comp;
  } dfip_analog_type;

  typedef struct packed {
    logic sdio_out;
    logic sdio_oe;
    logic alarm_serial_out;
  } dfip_serial_type;
endpackage

// ---- hw/dfip_top.sv ----
// framed double-data-rate byte input, fifo, divider sync, transmit gate and pin roles
// assumes all pins are asynchronous to mclk and toggle well below half its rate
`timescale 1ns/1ps
module dfip_top #(
  parameter int FIFO_AW = dfip_pkg::FIFO_AW,
  parameter logic [dfip_pkg::DIV_W-1:0] DIV_RATIO = dfip_pkg::DIV_RATIO_DEFAULT
) (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic forwarded_byte_clock, // ddr byte clock from the source
  input wire logic [dfip_pkg::LANE_W-1:0] byte_lanes, // ddr data lanes
  input wire logic frame_marker, // frame start marker
  input wire logic converter_clock, // converter sample clock
  input wire logic divider_sync_strobe, // divider reset strobe
  input wire logic transmit_gate, // high lets data through
  input wire logic lane_reverse, // swap lane significance
  input wire logic ext_ref_select, // high: reference pin is an input
  input wire logic four_wire_select, // high: read data on the alarm pin
  input wire logic serial_select_n, // serial access select, active low
  input wire logic serial_clock, // serial bit clock
  input wire logic sdio_in, // serial data pin, input side
  output dfip_pkg::dfip_serial_type serial_pins, // sdio drive, enable and alarm pin
  output logic reference_pin_oe, // high while reference is driven out
  output dfip_pkg::dfip_analog_type dac_codes, // sink codes of all four outputs
  output logic div_tick // one-cycle pulse of the divided converter clock
);
  import dfip_pkg::*;

  localparam int PW = FIFO_AW + 1;

  typedef struct packed {
    logic [2:0] bclk;
    logic [1:0][LANE_W-1:0] lanes;
    logic [1:0] frame;
    logic [2:0] cclk;
    logic [1:0] strobe;
    logic strobe_prev;
    logic [1:0] gate;
    logic [2:0] sclk;
    logic [1:0] sel_n;
    logic [1:0] sdi;
    logic [1:0] byte_idx;
    logic [23:0] acc;
    logic wr_en;
    logic [2*SAMPLE_W-1:0] wr_data;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [DIV_W-1:0] div_cnt;
    logic tick;
    logic rd_pend;
    logic rd_ok;
    logic overflow;
    logic ref_oe;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    dfip_serial_type ser;
    dfip_analog_type out;
  } dfip_st_type;

  dfip_st_type st_ff;
  dfip_st_type nxt_st;
  logic [2*SAMPLE_W-1:0] rd_word;

  function automatic logic [LANE_W-1:0] lane_order(input logic [LANE_W-1:0] b, input logic rev);
    logic [LANE_W-1:0] r;
    r = b;
    if (rev)
    begin
      for (int i = 0; i < LANE_W; i++)
      begin
        r[i] = b[LANE_W-1-i];
      end
    end
    return r;
  endfunction

  function automatic dfip_analog_type to_sinks(input dfip_pair_type p);
    dfip_analog_type s;
    s.a_true = ~p.a;
    s.a_comp = p.a;
    s.b_true = ~p.b;
    s.b_comp = p.b;
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic bclk_rise;
  logic bclk_fall;
  logic cclk_rise;
  logic sclk_rise;
  logic frame_start;
  logic fifo_full;
  logic fifo_empty;
  logic [LANE_W-1:0] in_byte;

  always_comb
  begin
    nxt_st = st_ff;
    bclk_rise = st_ff.bclk[1] & ~st_ff.bclk[2];
    bclk_fall = ~st_ff.bclk[1] & st_ff.bclk[2];
    cclk_rise = st_ff.cclk[1] & ~st_ff.cclk[2];
    sclk_rise = st_ff.sclk[1] & ~st_ff.sclk[2];
    frame_start = bclk_rise & st_ff.frame[1];
    fifo_full = (st_ff.wptr[FIFO_AW-1:0] == st_ff.rptr[FIFO_AW-1:0]) &&
                (st_ff.wptr[FIFO_AW] != st_ff.rptr[FIFO_AW]);
    fifo_empty = st_ff.wptr == st_ff.rptr;
    in_byte = lane_order(st_ff.lanes[1], lane_reverse);

    // two-flop synchronisers; third stage only for edge detection
    nxt_st.bclk = {st_ff.bclk[1:0], forwarded_byte_clock};
    nxt_st.lanes = {st_ff.lanes[0], byte_lanes};
    nxt_st.frame = {st_ff.frame[0], frame_marker};
    nxt_st.cclk = {st_ff.cclk[1:0], converter_clock};
    nxt_st.strobe = {st_ff.strobe[0], divider_sync_strobe};
    nxt_st.gate = {st_ff.gate[0], transmit_gate};
    nxt_st.sclk = {st_ff.sclk[1:0], serial_clock};
    nxt_st.sel_n = {st_ff.sel_n[0], serial_select_n};
    nxt_st.sdi = {st_ff.sdi[0], sdio_in};

    // byte assembly: a msb, a lsb, b msb, b lsb
    nxt_st.wr_en = 1'b0;
    if (st_ff.gate[1] && (bclk_rise || bclk_fall))
    begin
      if (frame_start)
      begin
        nxt_st.acc = {16'h0000, in_byte};
        nxt_st.byte_idx = FIRST_NEXT_IDX;
        nxt_st.wptr = '0;
        nxt_st.rptr = '0;
      end
      else if (st_ff.byte_idx == LAST_BYTE_IDX)
      begin
        nxt_st.byte_idx = 2'h0;
        if (fifo_full)
        begin
          nxt_st.overflow = 1'b1;
        end
        else
        begin
          nxt_st.wr_en = 1'b1;
          nxt_st.wr_data = {st_ff.acc, in_byte};
          nxt_st.wptr = st_ff.wptr + 1'b1;
        end
      end
      else
      begin
        nxt_st.acc = {st_ff.acc[15:0], in_byte};
        nxt_st.byte_idx = st_ff.byte_idx + 1'b1;
      end
    end

    // converter clock divider and fifo read
    nxt_st.tick = 1'b0;
    nxt_st.rd_pend = 1'b0;
    nxt_st.rd_ok = st_ff.rd_pend;
    if (cclk_rise)
    begin
      nxt_st.strobe_prev = st_ff.strobe[1];
      if (st_ff.strobe[1] && !st_ff.strobe_prev)
      begin
        nxt_st.div_cnt = '0;
      end
      else if (st_ff.div_cnt >= DIV_RATIO - 1'b1)
      begin
        nxt_st.div_cnt = '0;
        nxt_st.tick = 1'b1;
        // a frame start flushes this cycle, so the read waits for the next tick
        if (!fifo_empty && !frame_start)
        begin
          nxt_st.rptr = st_ff.rptr + 1'b1;
          nxt_st.rd_pend = 1'b1;
        end
      end
      else
      begin
        nxt_st.div_cnt = st_ff.div_cnt + 1'b1;
      end
    end

    if (!st_ff.gate[1])
    begin
      nxt_st.out = to_sinks('{a: ZERO_CODE, b: ZERO_CODE});
    end
    // memory read data stands one cycle after the pointer moves
    else if (st_ff.rd_ok)
    begin
      nxt_st.out = to_sinks(rd_word);
    end

    nxt_st.ref_oe = ~ext_ref_select;

    // serial port: 8 bits in, then the same byte echoed out
    if (st_ff.sel_n[1])
    begin
      nxt_st.bit_cnt = 4'h0;
      nxt_st.ser.sdio_oe = 1'b0;
    end
    else if (sclk_rise)
    begin
      if (st_ff.bit_cnt < SER_CMD_BITS)
      begin
        nxt_st.shreg = {st_ff.shreg[6:0], st_ff.sdi[1]};
      end
      else
      begin
        nxt_st.shreg = {st_ff.shreg[6:0], 1'b0};
      end
      if (st_ff.bit_cnt != SER_ALL_BITS)
      begin
        nxt_st.bit_cnt = st_ff.bit_cnt + 1'b1;
      end
      if (nxt_st.bit_cnt >= SER_CMD_BITS)
      begin
        nxt_st.ser.sdio_out = nxt_st.shreg[7];
        nxt_st.ser.sdio_oe = ~four_wire_select;
      end
    end
    // alarm pin idles high (no fault) unless read data is routed there
    nxt_st.ser.alarm_serial_out = four_wire_select ? nxt_st.ser.sdio_out : ~st_ff.overflow;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_ff <= '0;
      st_ff.out <= to_sinks('{a: ZERO_CODE, b: ZERO_CODE});
      st_ff.ref_oe <= 1'b1;
      st_ff.ser.alarm_serial_out <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  dfip_mem #(
    .WIDTH(2 * SAMPLE_W),
    .AW(FIFO_AW)
  ) u_mem (
    .mclk(mclk),
    .wr_en(st_ff.wr_en),
    .wr_addr(st_ff.wptr[FIFO_AW-1:0] - 1'b1),
    .wr_data(st_ff.wr_data),
    .rd_addr(st_ff.rptr[FIFO_AW-1:0] - 1'b1),
    .rd_data(rd_word)
  );

  assign serial_pins = st_ff.ser;
  assign reference_pin_oe = st_ff.ref_oe;
  assign dac_codes = st_ff.out;
  assign div_tick = st_ff.tick;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_frame_edge;
    st_ff.gate[1] && st_ff.bclk[1] && !st_ff.bclk[2] && st_ff.frame[1];
  endsequence

  sequence s_strobe_edge;
    st_ff.cclk[1] && !st_ff.cclk[2] && st_ff.strobe[1] && !st_ff.strobe_prev;
  endsequence

  a_gate_blocks_write: assert property (!st_ff.gate[1] |=> !st_ff.wr_en)
    else $error("write while gate low");
  a_gate_zero_out: assert property (!st_ff.gate[1] |=> st_ff.out.a_comp == ZERO_CODE && st_ff.out.b_true == 16'hffff)
    else $error("output not zero code while gate low");
  a_comp_inverse: assert property (st_ff.out.a_comp == ~st_ff.out.a_true && st_ff.out.b_comp == ~st_ff.out.b_true)
    else $error("complement output not inverse");
  a_frame_restart: assert property (s_frame_edge |=> st_ff.byte_idx == FIRST_NEXT_IDX)
    else $error("frame did not restart byte count");
  a_frame_fifo_reset: assert property (s_frame_edge |=> st_ff.wptr == '0 && !st_ff.wr_en)
    else $error("frame did not reset fifo");
  a_ddr_fall_capture: assert property (st_ff.gate[1] && !st_ff.bclk[1] && st_ff.bclk[2] && st_ff.byte_idx != LAST_BYTE_IDX
    |=> st_ff.byte_idx == $past(st_ff.byte_idx) + 2'h1)
    else $error("falling edge byte not taken");
  a_strobe_div_reset: assert property (s_strobe_edge |=> st_ff.div_cnt == '0 && !st_ff.tick)
    else $error("strobe did not reset divider");
  a_ref_pin_role: assert property (##1 st_ff.ref_oe == !$past(ext_ref_select))
    else $error("reference pin role wrong");
  a_four_wire_route: assert property (four_wire_select |=> !st_ff.ser.sdio_oe || $past(st_ff.ser.sdio_oe))
    else $error("sdio driven in four-wire read");
  a_sel_release: assert property (st_ff.sel_n[1] |=> !st_ff.ser.sdio_oe)
    else $error("sdio driven while deselected");
  a_read_to_out: assert property (st_ff.gate[1] && st_ff.rd_ok |=> st_ff.out.a_comp == $past(rd_word[31:16]) && st_ff.out.b_comp == $past(rd_word[15:0]))
    else $error("read word not passed to outputs");
  a_alarm_route: assert property (four_wire_select |=> st_ff.ser.alarm_serial_out == st_ff.ser.sdio_out)
    else $error("alarm pin not carrying read data");
endmodule
